// *** core/imrc_pkg.sv ***
// Constants for the bus mode and rate control block.
// Assumes a single 10 MHz core clock and a plain register port.
package imrc_pkg;
	localparam int CLK_MHZ = 10;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_OWN = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
	localparam logic [3:0] ADDR_RX_DATA = 4'h4;
	localparam logic [3:0] ADDR_BUS_STAT = 4'h5;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_RX_INHIBIT = 6;
	localparam int BIT_MASTER = 5;
	localparam int BIT_TRANSMIT = 4;
	localparam int BIT_RATE_HI = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [6:0] OWN_RESET = 7'h00;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam int IRQ_ARB = 0;
	localparam int IRQ_ADDR = 1;
	localparam int IRQ_OVR = 2;
	localparam int IRQ_RXBYTE = 3;
	localparam int SETUP_SHORT_CYC = 10;
	localparam int SETUP_LONG_CYC = 20;
	localparam logic [8:0] DIV_TBL_LO [8] = '{9'h01C, 9'h028, 9'h030,
		9'h040, 9'h050, 9'h064, 9'h070, 9'h080};
	localparam logic [8:0] DIV_TBL_HI [8] = '{9'h038, 9'h050, 9'h060,
		9'h080, 9'h0A0, 9'h0C8, 9'h0E0, 9'h100};
	typedef enum logic [1:0] {
		IMRC_SLV_RX,
		IMRC_SLV_TX,
		IMRC_MST_RX,
		IMRC_MST_TX
	} imrc_mode_t;
endpackage

// *** core/imrc_rate_gen.sv ***
// Master transfer clock divider with a slave transmit setup timer.
// Assumes the divider and mode inputs stay stable during a transfer.
`timescale 1ns/1ps
module imrc_rate_gen (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic run_in,
	input wire logic master_in,
	input wire logic [3:0] rate_sel_in,
	input wire logic setup_start_in,
	output logic scl_tick_out,
	output logic setup_done_out
);
	logic [8:0] div_cyc;
	logic [8:0] cnt_q;
	logic [4:0] setup_q;
	logic setup_busy_q;

	function automatic logic [8:0] div_of(input logic [3:0] sel);
		div_of = sel[3] ? imrc_pkg::DIV_TBL_HI[sel[2:0]] :
			imrc_pkg::DIV_TBL_LO[sel[2:0]];
	endfunction

	assign div_cyc = div_of(rate_sel_in);

	// Tick marks one half of an SCL period.
	always_ff @(posedge core_clk_in) begin
		if (srst_in || !run_in || !master_in) begin
			cnt_q <= 9'h000;
			scl_tick_out <= 1'b0;
		end else if (cnt_q >= (div_cyc >> 1) - 9'h001) begin
			cnt_q <= 9'h000;
			scl_tick_out <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 9'h001;
			scl_tick_out <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in || !run_in) begin
			setup_q <= 5'h00;
			setup_busy_q <= 1'b0;
			setup_done_out <= 1'b0;
		end else if (setup_start_in) begin
			setup_q <= rate_sel_in[3] ? 5'(imrc_pkg::SETUP_LONG_CYC - 1) :
				5'(imrc_pkg::SETUP_SHORT_CYC - 1);
			setup_busy_q <= 1'b1;
			setup_done_out <= 1'b0;
		end else if (setup_busy_q && setup_q == 5'h00) begin
			setup_busy_q <= 1'b0;
			setup_done_out <= 1'b1;
		end else begin
			if (setup_busy_q) begin
				setup_q <= setup_q - 5'h01;
			end
			setup_done_out <= 1'b0;
		end
	end
endmodule

// *** core/imrc_top.sv ***
// Mode and rate control for a two-wire or clocked synchronous interface.
// Assumes the shifter reports events as one-cycle pulses on this clock.
`timescale 1ns/1ps
// Behaviour
// - With enable low the block is halted and the pins go back to port use.
// - A read of the received byte starts the next reception in receive direction unless inhibited.
// - Lost arbitration as master in two-wire format clears master and transmit.
// - A slave address match with read bit set sets the transmit bit.
// - An overrun as master in synchronous format clears the master bit.
// - Master and transmit bits encode the four operating modes.
// - In synchronous format the clock pin is driven while master is set.
// - The rate field selects the master clock divider from two tables.
// - Slave transmit setup time is 10 or 20 clocks by the top rate bit.
module imrc_top (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic irq_out,
	input wire logic sync_format_in,
	input wire logic arb_lost_in,
	input wire logic addr_byte_valid_in,
	input wire logic [7:0] addr_byte_in,
	input wire logic overrun_in,
	input wire logic rx_byte_valid_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic frame_active_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic bus_owns_pins_out,
	output logic scl_out,
	output logic scl_oe_out,
	output logic rx_start_out,
	output logic [1:0] mode_out,
	output logic scl_tick_out,
	output logic setup_done_out
);
	logic [7:0] ctrl_q;
	logic [6:0] own_q;
	logic [3:0] stat_q;
	logic [3:0] mask_q;
	logic [7:0] rx_q;
	logic [3:0] ev;
	logic wr_ctrl;
	logic addr_hit;
	logic enable;
	logic master;
	logic transmit;
	logic scl_lvl_q;
	logic tx_q;
	imrc_pkg::imrc_mode_t mode;

	assign enable = ctrl_q[imrc_pkg::BIT_ENABLE];
	assign master = ctrl_q[imrc_pkg::BIT_MASTER];
	assign transmit = ctrl_q[imrc_pkg::BIT_TRANSMIT];
	assign wr_ctrl = wr_in && addr_in == imrc_pkg::ADDR_CTRL;
	assign addr_hit = enable && !master && !transmit && !sync_format_in &&
		addr_byte_valid_in && addr_byte_in[7:1] == own_q &&
		addr_byte_in[0];

	// Mode changes by hardware take precedence over a software write.
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			ctrl_q <= imrc_pkg::CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wdata_in;
				if (frame_active_in) begin
					ctrl_q[imrc_pkg::BIT_TRANSMIT] <= transmit;
				end
			end
			if (enable && master && !sync_format_in && arb_lost_in) begin
				ctrl_q[imrc_pkg::BIT_MASTER] <= 1'b0;
				ctrl_q[imrc_pkg::BIT_TRANSMIT] <= 1'b0;
			end else if (enable && master && sync_format_in && overrun_in) begin
				ctrl_q[imrc_pkg::BIT_MASTER] <= 1'b0;
			end else if (addr_hit) begin
				ctrl_q[imrc_pkg::BIT_TRANSMIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			own_q <= imrc_pkg::OWN_RESET;
		end else if (wr_in && addr_in == imrc_pkg::ADDR_OWN) begin
			own_q <= wdata_in[7:1];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			rx_q <= 8'h00;
		end else if (rx_byte_valid_in) begin
			rx_q <= rx_byte_in;
		end
	end

	// A read of the received byte reopens reception in receive direction.
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			rx_start_out <= 1'b0;
		end else begin
			rx_start_out <= rd_in && addr_in == imrc_pkg::ADDR_RX_DATA &&
				enable && !transmit &&
				!ctrl_q[imrc_pkg::BIT_RX_INHIBIT];
		end
	end

	assign ev[imrc_pkg::IRQ_ARB] = enable && master && !sync_format_in &&
		arb_lost_in;
	assign ev[imrc_pkg::IRQ_ADDR] = addr_hit;
	assign ev[imrc_pkg::IRQ_OVR] = enable && master && sync_format_in &&
		overrun_in;
	assign ev[imrc_pkg::IRQ_RXBYTE] = rx_byte_valid_in;

	// Set wins over a write-one clear in the same cycle.
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			stat_q <= imrc_pkg::IRQ_RESET;
		end else if (wr_in && addr_in == imrc_pkg::ADDR_IRQ_STAT) begin
			stat_q <= (stat_q & ~wdata_in[3:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			mask_q <= imrc_pkg::IRQ_RESET;
		end else if (wr_in && addr_in == imrc_pkg::ADDR_IRQ_MASK) begin
			mask_q <= wdata_in[3:0];
		end
	end

	assign irq_out = |(stat_q & mask_q);

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				imrc_pkg::ADDR_CTRL: rdata_out <= ctrl_q;
				imrc_pkg::ADDR_OWN: rdata_out <= {own_q, 1'b0};
				imrc_pkg::ADDR_IRQ_STAT: rdata_out <= {4'h0, stat_q};
				imrc_pkg::ADDR_IRQ_MASK: rdata_out <= {4'h0, mask_q};
				imrc_pkg::ADDR_RX_DATA: rdata_out <= rx_q;
				imrc_pkg::ADDR_BUS_STAT: rdata_out <= {4'h0, scl_in, sda_in,
					mode_out};
				default: rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	always_comb begin
		unique case ({master, transmit})
			2'b00: mode = imrc_pkg::IMRC_SLV_RX;
			2'b01: mode = imrc_pkg::IMRC_SLV_TX;
			2'b10: mode = imrc_pkg::IMRC_MST_RX;
			2'b11: mode = imrc_pkg::IMRC_MST_TX;
		endcase
	end

	assign mode_out = mode;
	assign bus_owns_pins_out = enable;

	// SCL toggles on each half period tick while the master drives it.
	always_ff @(posedge core_clk_in) begin
		if (srst_in || !enable || !master) begin
			scl_lvl_q <= 1'b1;
		end else if (scl_tick_out) begin
			scl_lvl_q <= ~scl_lvl_q;
		end
	end

	assign scl_out = scl_lvl_q;
	assign scl_oe_out = enable && sync_format_in && master;

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			tx_q <= 1'b0;
		end else begin
			tx_q <= mode == imrc_pkg::IMRC_SLV_TX;
		end
	end

	imrc_rate_gen u_rate (
		.core_clk_in(core_clk_in),
		.srst_in(srst_in),
		.run_in(enable),
		.master_in(master),
		.rate_sel_in(ctrl_q[imrc_pkg::BIT_RATE_HI:0]),
		.setup_start_in(mode == imrc_pkg::IMRC_SLV_TX && !tx_q),
		.scl_tick_out(scl_tick_out),
		.setup_done_out(setup_done_out)
	);
endmodule

// *** verif/imrc_chk.sv ***
// Port checker for the mode and rate control block.
// Assumes it is bound into imrc_top and sees only its ports.
`timescale 1ns/1ps
module imrc_chk (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic irq_out,
	input wire logic sync_format_in,
	input wire logic arb_lost_in,
	input wire logic addr_byte_valid_in,
	input wire logic overrun_in,
	input wire logic frame_active_in,
	input wire logic bus_owns_pins_out,
	input wire logic scl_oe_out,
	input wire logic rx_start_out,
	input wire logic [1:0] mode_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	logic cw;
	logic hw;
	assign cw = wr_in && addr_in == 4'h0;
	assign hw = arb_lost_in | overrun_in | addr_byte_valid_in;
	property p_en; cw |=> bus_owns_pins_out == $past(wdata_in[7]); endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	property p_rx;
		rx_start_out |-> $past(rd_in && addr_in == 4'h4 && !mode_out[0]);
	endproperty
	a_rx: assert property (p_rx) else $error("rx start wrong");
	property p_arb; arb_lost_in && !sync_format_in && mode_out[1] &&
		bus_owns_pins_out |=> mode_out == 2'h0; endproperty
	a_arb: assert property (p_arb) else $error("arb mode wrong");
	property p_frm; cw && frame_active_in && !hw |=>
		mode_out[0] == $past(mode_out[0]); endproperty
	a_frm: assert property (p_frm) else $error("tx bit moved");
	property p_ovr; overrun_in && sync_format_in && mode_out[1] &&
		bus_owns_pins_out |=> !mode_out[1]; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun mode wrong");
	property p_md; cw && !frame_active_in && !hw |=>
		mode_out == $past(wdata_in[5:4]); endproperty
	a_md: assert property (p_md) else $error("mode wrong");
	property p_oe; scl_oe_out ==
		(bus_owns_pins_out && sync_format_in && mode_out[1]); endproperty
	a_oe: assert property (p_oe) else $error("clock drive wrong");
	property p_rst; $fell(srst_in) |->
		!bus_owns_pins_out && mode_out == 2'h0 && !irq_out; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind imrc_top imrc_chk u_chk (.*);

// *** verif/imrc_peer.sv ***
// Far-side bus device: pulled-up open-drain clock and data lines.
// Assumes the block drives only the clock line.
`timescale 1ns/1ps
module imrc_peer (
	input wire logic scl_drv_in,
	input wire logic scl_oe_in,
	output logic scl_line_out,
	output logic sda_line_out
);
	assign scl_line_out = scl_oe_in ? scl_drv_in : 1'h1;
	assign sda_line_out = 1'h1;
endmodule

// *** verif/imrc_top_tb.sv ***
// Self-checking bench for the mode and rate control block.
// Assumes a 10 MHz clock and the register map of the package.
`timescale 1ns/1ps
module imrc_top_tb;
	logic core_clk_in, srst_in, wr_in, rd_in, irq_out, sync_format_in;
	logic arb_lost_in, addr_byte_valid_in, overrun_in, rx_byte_valid_in;
	logic frame_active_in, scl_in, sda_in, bus_owns_pins_out, scl_out;
	logic scl_oe_out, rx_start_out, scl_tick_out, setup_done_out, rdp;
	logic [3:0] addr_in;
	logic [7:0] wdata_in, rdata_out, addr_byte_in, rx_byte_in, exp_q[$];
	logic [1:0] mode_out;
	logic [31:0] sd = 32'h7C5E;
	int n_errors = 0, checked = 0, cyc = 0, n;
	imrc_top uut (.*);
	imrc_peer peer (.scl_drv_in(scl_out), .scl_oe_in(scl_oe_out),
		.scl_line_out(scl_in), .sda_line_out(sda_in));
	always #50 core_clk_in = ~core_clk_in;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [8:0] e, s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'h1;
		@(posedge core_clk_in);
		wr_in <= 1'h0;
		@(negedge core_clk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'h1;
		@(posedge core_clk_in);
		rd_in <= 1'h0;
		@(negedge core_clk_in);
	endtask
	task automatic pulse(input int w);
		@(posedge core_clk_in);
		arb_lost_in <= w == 0;
		overrun_in <= w == 1;
		addr_byte_valid_in <= w == 2;
		rx_byte_valid_in <= w == 3;
		@(posedge core_clk_in);
		{arb_lost_in, overrun_in} <= 2'h0;
		{addr_byte_valid_in, rx_byte_valid_in} <= 2'h0;
		@(negedge core_clk_in);
	endtask
	task automatic wait_on(input int w);
		n = 0;
		do begin
			@(negedge core_clk_in);
			n++;
		end while (!(w ? setup_done_out : scl_tick_out) && n < 300);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(negedge core_clk_in) begin
		if (rdp)
			chk("rdata", exp_q.pop_front(), rdata_out);
		rdp = rd_in;
	end
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{core_clk_in, wr_in, rd_in, sync_format_in, arb_lost_in, rdp} = '0;
		{addr_byte_valid_in, overrun_in, rx_byte_valid_in} = '0;
		{frame_active_in, addr_in, wdata_in, addr_byte_in, rx_byte_in} = '0;
		srst_in = 1'h1;
		repeat (12) @(posedge core_clk_in);
		srst_in <= 1'h0;
		rd(4'h0, 8'h00);
		rd(4'hF, 8'h00);
		rd(4'h5, 8'h0C);
		chk("scl", 1'h1, scl_out);
		chk("pins", 1'h0, bus_owns_pins_out);
		wr(4'h0, 8'h80);
		chk("pins", 1'h1, bus_owns_pins_out);
		for (int m = 0; m < 4; m++) begin
			wr(4'h0, {2'h2, m[1:0], 4'h0});
			chk("mode", m[1:0], mode_out);
		end
		pulse(0);
		rd(4'h0, 8'h80);
		@(posedge core_clk_in);
		frame_active_in <= 1'h1;
		wr(4'h0, 8'h90);
		chk("mode", 2'h0, mode_out);
		@(posedge core_clk_in);
		frame_active_in <= 1'h0;
		sync_format_in <= 1'h1;
		wr(4'h0, 8'hA0);
		chk("oe", 1'h1, scl_oe_out);
		pulse(1);
		chk("mode", 2'h0, mode_out);
		chk("oe", 1'h0, scl_oe_out);
		@(posedge core_clk_in);
		sync_format_in <= 1'h0;
		sd = xs(sd);
		wr(4'h1, {sd[6:0], 1'h0});
		rd(4'h1, {sd[6:0], 1'h0});
		@(posedge core_clk_in);
		addr_byte_in <= {sd[6:0], 1'h1};
		for (int k = 0; k < 2; k++) begin
			wr(4'h0, {4'h8, k[0], 3'h0});
			pulse(2);
			chk("mode", 2'h1, mode_out);
			wait_on(1);
			chk("setup", k ? 9'(imrc_pkg::SETUP_LONG_CYC + 1) :
				9'(imrc_pkg::SETUP_SHORT_CYC + 1), 9'(n));
		end
		chk("irq", 1'h0, irq_out);
		rd(4'h2, 8'h07);
		wr(4'h3, 8'h02);
		rd(4'h3, 8'h02);
		chk("irq", 1'h1, irq_out);
		wr(4'h2, 8'h02);
		rd(4'h2, 8'h05);
		chk("irq", 1'h0, irq_out);
		wr(4'h0, 8'h80);
		@(posedge core_clk_in);
		rx_byte_in <= sd[15:8];
		pulse(3);
		rd(4'h4, sd[15:8]);
		chk("rxs", 1'h1, rx_start_out);
		wr(4'h0, 8'hC0);
		rd(4'h4, sd[15:8]);
		chk("rxs", 1'h0, rx_start_out);
		for (int c = 0; c < 16; c++) begin
			wr(4'h0, {4'hA, c[3:0]});
			wait_on(0);
			wait_on(0);
			chk("div", c[3] ? imrc_pkg::DIV_TBL_HI[c % 8] :
				imrc_pkg::DIV_TBL_LO[c % 8], 9'(2 * n));
		end
		end_sim();
	end
endmodule
